// file: hdl/mia_arbiter.sv
// maskable interrupt arbiter and acknowledge sequencer
//
// What this block does
// (R01) every acknowledge loads the program counter with 00FF
// (R02) software trap ranks highest, default vector entry ranks lowest
// (R03) eleven maskable inputs with fixed rank and fixed vector slot
// (R04) every source but the trap has one enable and one pending flag
// (R05) source event sets its pending flag regardless of enable
// (R06) maskable fires only with enable, global enable, no trap routine
// (R07) requests are judged only at instruction start
// (R08) simultaneous requests: highest rank served, others stay pending
// (R09) reset clears pending flags, enables and global enable
// (R10) flag already pending when enabled fires at once
// (R11) source active bit follows enable and pending both set, one cycle later
// (R12) a pending skip completes before any acknowledge
// (R13) acknowledge start clears the global enable
// (R14) acknowledge pushes the address about to execute
// (R15) whole acknowledge sequence takes seven instruction cycles
// (R16) software setting global enable in the status word allows nesting
// (R17) pending and enable bits are software readable and writable
// (R18) return sets global enable and reloads the popped address
// (R19) still pending requests taken right after return
// (R20) service routine clears its own pending flag early
// (R21) vector select yields even byte E0..FE, upper PC byte kept
// (R22) no active source selects default vector E0
// (R23) event and clear in one cycle: the set wins
`include "mia_params.svh"

module mia_arbiter (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   srst,
   // peripheral events
   input  wire logic [`MIA_NSRC-1:0]   src_event,
   input  wire logic                   trap_event,
   input  wire logic                   trap_clear,
   // software register writes
   input  wire mia_pkg::mia_sw_wr_t    sw_wr,
   // sequencer
   input  wire logic                   instr_start,
   input  wire logic                   skip_pending,
   input  wire logic                   vis_exec,
   input  wire logic                   return_from_service,
   input  wire logic [`MIA_PC_W-1:0]   pc_in,
   input  wire logic [`MIA_PC_W-1:0]   pop_addr,
   // register read back
   output logic      [`MIA_NSRC-1:0]   pend,
   output logic      [`MIA_NSRC-1:0]   en,
   output logic                        global_irq_enable,
   output logic      [`MIA_NSRC-1:0]   active,
   output logic                        trap_pend,
   output logic                        trap_busy,
   // acknowledge and program counter control
   output logic                        ack_busy,
   output logic                        push_valid,
   output logic      [`MIA_PC_W-1:0]   push_addr,
   output logic                        pc_load,
   output logic      [`MIA_PC_W-1:0]   pc_value
);

   mia_pkg::mia_state_t  state;
   logic [2:0]           ack_cnt;
   logic [`MIA_NSRC-1:0] next_active;
   logic                 trap_req;
   logic                 mask_req;
   logic                 take;
   logic [7:0]           vec_byte;

   // (R11) active when enabled and pending
   assign next_active = pend & en;

   // (R06) maskable qualification
   // (R10) stale flag fires once enabled
   // (R19) pending retaken after return
   assign mask_req = global_irq_enable && (|next_active)
                     && !trap_busy;
   assign trap_req = trap_pend && !trap_busy;

   // (R07) judged only at instruction start
   // (R12) held off while a skip is in progress
   assign take = instr_start && !skip_pending
                 && (state == mia_pkg::MIA_IDLE)
                 && (trap_req || mask_req);

   // (R03) per source pending flag, one entry each
   // (R04) one flag per maskable source
   genvar g;
   generate
      for (g = 0; g < `MIA_NSRC; g++) begin : g_src
         // (R05) event sets flag, (R23) set beats clear
         always_ff @(posedge clk) begin
            if (srst) begin
               pend[g] <= 1'b0;
            end else if (src_event[g]) begin
               pend[g] <= 1'b1;
            end else if (sw_wr.pend_wr) begin
               pend[g] <= sw_wr.pend_data[g];
            end
         end
      end
   endgenerate

   // (R17) enable register, (R09) cleared by reset
   always_ff @(posedge clk) begin
      if (srst) begin
         en <= '0;
      end else if (sw_wr.en_wr) begin
         en <= sw_wr.en_data;
      end
   end

   // (R13) global enable cleared on take
   // (R16) software write, (R18) return sets it
   always_ff @(posedge clk) begin
      if (srst) begin
         global_irq_enable <= 1'b0;
      end else if (take) begin
         global_irq_enable <= 1'b0;
      end else if (return_from_service) begin
         global_irq_enable <= 1'b1;
      end else if (sw_wr.gie_wr) begin
         global_irq_enable <= sw_wr.gie_data;
      end
   end

   // registered copy of active sources
   always_ff @(posedge clk) begin
      if (srst) begin
         active <= '0;
      end else begin
         active <= next_active;
      end
   end

   // (R02) trap pending, set wins over clear
   always_ff @(posedge clk) begin
      if (srst) begin
         trap_pend <= 1'b0;
      end else if (trap_event) begin
         trap_pend <= 1'b1;
      end else if (trap_clear) begin
         trap_pend <= 1'b0;
      end
   end

   // trap routine in progress until its flag is cleared
   always_ff @(posedge clk) begin
      if (srst) begin
         trap_busy <= 1'b0;
      end else if (take && trap_req) begin
         trap_busy <= 1'b1;
      end else if (trap_clear && !trap_event) begin
         trap_busy <= 1'b0;
      end
   end

   // (R15) seven cycle acknowledge sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         state   <= mia_pkg::MIA_IDLE;
         ack_cnt <= 3'h0;
      end else begin
         case (state)
            mia_pkg::MIA_IDLE: begin
               if (take) begin
                  state   <= mia_pkg::MIA_ACK;
                  ack_cnt <= 3'h1;
               end
            end
            mia_pkg::MIA_ACK: begin
               if (ack_cnt == `MIA_ACK_CYCLES) begin
                  state   <= mia_pkg::MIA_IDLE;
                  ack_cnt <= 3'h0;
               end else begin
                  ack_cnt <= ack_cnt + 3'h1;
               end
            end
            default: begin
               state <= mia_pkg::MIA_IDLE;
            end
         endcase
      end
   end

   // busy flag mirrors the sequencer
   always_ff @(posedge clk) begin
      if (srst) begin
         ack_busy <= 1'b0;
      end else if (take) begin
         ack_busy <= 1'b1;
      end else if (ack_cnt == `MIA_ACK_CYCLES) begin
         ack_busy <= 1'b0;
      end
   end

   // (R14) return address captured and pushed
   always_ff @(posedge clk) begin
      if (srst) begin
         push_addr  <= '0;
         push_valid <= 1'b0;
      end else begin
         if (take) begin
            push_addr <= pc_in;
         end
         push_valid <= (state == mia_pkg::MIA_ACK)
                       && (ack_cnt == `MIA_PUSH_STEP);
      end
   end

   // vector byte of highest ranked request
   mia_vec_sel u_vec (
      .trap_act (trap_pend),
      .active   (next_active),
      .vec_byte (vec_byte)
   );

   // program counter loads: service entry, return, vector select
   always_ff @(posedge clk) begin
      if (srst) begin
         pc_load  <= 1'b0;
         pc_value <= '0;
      end else if ((state == mia_pkg::MIA_ACK)
                   && (ack_cnt == `MIA_ACK_CYCLES)) begin
         // (R01) fixed service entry
         pc_load  <= 1'b1;
         pc_value <= `MIA_SVC_ADDR;
      end else if (return_from_service) begin
         // (R18) popped address restored
         pc_load  <= 1'b1;
         pc_value <= pop_addr;
      end else if (vis_exec) begin
         // (R21) low byte replaced, (R22) default E0
         pc_load  <= 1'b1;
         pc_value <= {pc_in[`MIA_PC_W-1:8], vec_byte};
      end else begin
         pc_load  <= 1'b0;
      end
   end

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   chk_svc_entry: assert property ( // R01
      take |-> ##8 (pc_load && pc_value == `MIA_SVC_ADDR))
      else $error("service entry not loaded at end of acknowledge");

   chk_trap_first: assert property ( // R02
      (vis_exec && trap_pend && !return_from_service
       && !(state == mia_pkg::MIA_ACK && ack_cnt == 3'h7))
      |=> pc_value[7:0] == `MIA_VEC_TRAP)
      else $error("trap did not win vector select");

   chk_pend_set: assert property ( // R05
      (|src_event) |=> (pend & $past(src_event)) == $past(src_event))
      else $error("event did not set pending flag");

   chk_gate: assert property ( // R06
      $rose(ack_busy) |-> $past(!trap_busy && (trap_pend
         || (global_irq_enable && |(pend & en)))))
      else $error("take without qualified request");

   chk_boundary: assert property ( // R07
      $rose(ack_busy) |-> $past(instr_start && !skip_pending))
      else $error("take outside instruction start");

   chk_reset_clr: assert property ( // R09
      disable iff (1'b0)
      srst |=> (pend == '0 && en == '0 && !global_irq_enable))
      else $error("reset left flags set");

   chk_active_eq: assert property ( // R11
      active == $past(pend & en))
      else $error("active differs from pend and enable");

   chk_gie_clear: assert property ( // R13
      take |=> !global_irq_enable && ack_busy)
      else $error("global enable not cleared on take");

   chk_push: assert property ( // R14
      take ##3 1'b1 |-> push_valid && push_addr == $past(pc_in, 3))
      else $error("return address not pushed");

   chk_ack_len: assert property ( // R15
      take |=> ack_busy [*7] ##1 !ack_busy)
      else $error("acknowledge not seven cycles");

   chk_return: assert property ( // R18
      return_from_service && !take
      |=> global_irq_enable && pc_load)
      else $error("return did not restore enable");

   chk_vec_even: assert property ( // R21
      vis_exec && !return_from_service && state == mia_pkg::MIA_IDLE
      |=> pc_value[0] == 1'b0 && pc_value[7:5] == 3'h7
          && pc_value[14:8] == $past(pc_in[14:8]))
      else $error("vector byte out of range");

   chk_set_wins: assert property ( // R23
      sw_wr.pend_wr && |(src_event & ~sw_wr.pend_data)
      |=> (pend & $past(src_event)) == $past(src_event))
      else $error("clear beat a simultaneous event");

   cov_mask_take: cover property (
      take && !trap_req ##8 pc_load);
   cov_trap_take: cover property (take && trap_req);
   cov_retake: cover property (
      return_from_service ##[1:4] take);

endmodule

// file: hdl/mia_params.svh
// constants of the maskable interrupt arbiter
`ifndef MIA_PARAMS_SVH
`define MIA_PARAMS_SVH

// source count and widths
`define MIA_NSRC       11
`define MIA_PC_W       15

// fixed service entry and vector page bytes
`define MIA_SVC_ADDR   15'h00ff
`define MIA_VEC_TRAP   8'hfe
`define MIA_VEC_DFLT   8'he0

// vector byte of each maskable source, index 0 ranks highest
`define MIA_VEC_S0     8'hfc
`define MIA_VEC_S1     8'hfa
`define MIA_VEC_S2     8'hf8
`define MIA_VEC_S3     8'hf6
`define MIA_VEC_S4     8'hf4
`define MIA_VEC_S5     8'hf2
`define MIA_VEC_S6     8'hf0
`define MIA_VEC_S7     8'hee
`define MIA_VEC_S8     8'hec
`define MIA_VEC_S9     8'hea
`define MIA_VEC_S10    8'he2

// acknowledge timing in instruction cycles
`define MIA_ACK_CYCLES 3'h7
`define MIA_PUSH_STEP  3'h2

`endif

// file: hdl/mia_pkg.sv
// types shared by the interrupt arbiter files
`include "mia_params.svh"

package mia_pkg;

   // acknowledge sequencer states
   typedef enum logic [0:0] {
      MIA_IDLE,
      MIA_ACK
   } mia_state_t;

   // software access to the flag and enable registers
   typedef struct packed {
      logic                    pend_wr;
      logic [`MIA_NSRC-1:0]    pend_data;
      logic                    en_wr;
      logic [`MIA_NSRC-1:0]    en_data;
      logic                    gie_wr;
      logic                    gie_data;
   } mia_sw_wr_t;

endpackage

// file: hdl/mia_vec_sel.sv
// vector byte selection by fixed rank
`include "mia_params.svh"

module mia_vec_sel (
   // requests
   input  wire logic                 trap_act,
   input  wire logic [`MIA_NSRC-1:0] active,
   // result
   output logic      [7:0]           vec_byte
);

   // fixed vector position of each source
   localparam logic [7:0] VEC_TAB [`MIA_NSRC] = '{
      `MIA_VEC_S0, `MIA_VEC_S1, `MIA_VEC_S2, `MIA_VEC_S3,
      `MIA_VEC_S4, `MIA_VEC_S5, `MIA_VEC_S6, `MIA_VEC_S7,
      `MIA_VEC_S8, `MIA_VEC_S9, `MIA_VEC_S10
   };

   // (R08) highest rank served first
   // walk lowest rank upward so the highest rank wins
   always_comb begin
      vec_byte = `MIA_VEC_DFLT;
      for (int i = `MIA_NSRC - 1; i >= 0; i--) begin
         if (active[i]) begin
            vec_byte = VEC_TAB[i];
         end
      end
      if (trap_act) begin
         vec_byte = `MIA_VEC_TRAP;
      end
   end

endmodule

// file: verification/mia_cpu_model.sv
// cpu sequencer stand-in: instruction starts, pc and return stack
module mia_cpu_model (
   // control
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        run,
   input  wire logic        ret,
   // arbiter outputs
   input  wire logic        ack_busy,
   input  wire logic        push_valid,
   input  wire logic [14:0] push_addr,
   input  wire logic        pc_load,
   input  wire logic [14:0] pc_value,
   // arbiter inputs
   output logic             instr_start,
   output logic      [14:0] pc_in,
   output logic      [14:0] pop_addr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [14:0] stack [$];

   // a start every other cycle, none while acknowledging
   always @(posedge clk) begin
      instr_start <= run && !srst && !ack_busy && !instr_start;
      if (srst)
         pc_in <= 15'h0123;
      else if (pc_load)
         pc_in <= pc_value;
      else if (instr_start)
         pc_in <= pc_in + 15'h0001;
      if (push_valid)
         stack.push_back(push_addr);
      if (ret && stack.size() != 0)
         void'(stack.pop_back());
      // empty stack shows a changing pattern, not a stale address
      if (srst)
         pop_addr <= 15'h0000;
      else
         pop_addr <= (stack.size() != 0) ? stack[$] : ~pop_addr;
   end
endmodule

// file: verification/test_mia_arbiter.sv
// self-checking bench for the interrupt arbiter
`define CHK(nm, ex, got) begin \
   compares++; \
   if ((got) !== (ex)) begin \
      n_fail++; \
      $display("Error %s expected %h seen %h", nm, ex, got); \
   end \
end

module test_mia_arbiter;
   timeunit 1ns;
   timeprecision 1ns;
   logic                clk, srst, trap_event, trap_clear, tb_start;
   logic                skip_pending, vis_go, ret, run, m_start;
   logic [10:0]         src_event, pend, en, active;
   logic                global_irq_enable, trap_pend, trap_busy;
   logic                ack_busy, push_valid, pc_load;
   logic [14:0]         pc_in, pop_addr, push_addr, pc_value, exp;
   mia_pkg::mia_sw_wr_t sw;
   int                  n_fail, compares, k;
   logic [7:0]          vtab [11] = '{8'hfc, 8'hfa, 8'hf8, 8'hf6,
      8'hf4, 8'hf2, 8'hf0, 8'hee, 8'hec, 8'hea, 8'he2};

   mia_arbiter dut (
      .clk(clk), .srst(srst), .src_event(src_event),
      .trap_event(trap_event), .trap_clear(trap_clear), .sw_wr(sw),
      .instr_start(tb_start | m_start), .skip_pending(skip_pending),
      .vis_exec(vis_go), .return_from_service(ret), .pc_in(pc_in),
      .pop_addr(pop_addr), .pend(pend), .en(en),
      .global_irq_enable(global_irq_enable), .active(active),
      .trap_pend(trap_pend), .trap_busy(trap_busy), .ack_busy(ack_busy),
      .push_valid(push_valid), .push_addr(push_addr), .pc_load(pc_load),
      .pc_value(pc_value));

   mia_cpu_model cpu (
      .clk(clk), .srst(srst), .run(run), .ret(ret), .ack_busy(ack_busy),
      .push_valid(push_valid), .push_addr(push_addr), .pc_load(pc_load),
      .pc_value(pc_value), .instr_start(m_start), .pc_in(pc_in),
      .pop_addr(pop_addr));

   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task automatic step(input int n = 1);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one-cycle register write: w = pend, enable, global enable strobes
   task automatic swr(input logic [2:0] w, input logic [10:0] p, e,
                      input logic g);
      sw = '{w[2], p, w[1], e, w[0], g};
      step();
      sw = '0;
   endtask

   task automatic final_report;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic t_reset;
      `CHK("pend", 11'h000, pend)
      `CHK("en", 11'h000, en)
      `CHK("gie", 1'b0, global_irq_enable)
      $display("test reset done");
   endtask

   task automatic t_flags;
      src_event = 11'h008;
      step();
      src_event = '0;
      `CHK("pend", 11'h008, pend)
      `CHK("active", 11'h000, active)
      swr(3'b010, '0, 11'h008, 1'b0);
      step();
      `CHK("active", 11'h008, active)
      src_event = 11'h008;
      swr(3'b100, '0, '0, 1'b0);
      src_event = '0;
      `CHK("set wins", 11'h008, pend)
      step();
      swr(3'b100, '0, '0, 1'b0);
      `CHK("cleared", 11'h000, pend)
      $display("test flags done");
   endtask

   task automatic t_ack;
      step();
      swr(3'b110, 11'h024, 11'h7ff, 1'b0);
      tb_start = 1'b1;
      step();
      tb_start = 1'b0;
      `CHK("masked", 1'b0, ack_busy)
      swr(3'b001, '0, '0, 1'b1);
      skip_pending = 1'b1;
      tb_start = 1'b1;
      step();
      `CHK("skip", 1'b0, ack_busy)
      skip_pending = 1'b0;
      exp = pc_in;
      step();
      `CHK("gie", 1'b0, global_irq_enable)
      `CHK("busy", 1'b1, ack_busy)
      step(2);
      tb_start = 1'b0;
      `CHK("push", 1'b1, push_valid)
      `CHK("push addr", exp, push_addr)
      step(4);
      `CHK("busy c7", 1'b1, ack_busy)
      step();
      `CHK("svc pc", 15'h00ff, pc_value)
      `CHK("load", 1'b1, pc_load)
      `CHK("busy end", 1'b0, ack_busy)
      `CHK("others", 11'h024, pend)
      exp = pc_in;
      vis_go = 1'b1;
      step();
      vis_go = 1'b0;
      `CHK("vis", {exp[14:8], 8'hf8}, pc_value)
      $display("test ack done");
   endtask

   task automatic t_vis;
      logic [7:0] eb;
      for (int i = 0; i < 13; i++) begin
         trap_event = (i == 12);
         swr(3'b100, (i < 11) ? 11'(1 << i) : {11{i == 12}}, '0, 1'b0);
         trap_event = 1'b0;
         exp = pc_in;
         vis_go = 1'b1;
         step();
         vis_go = 1'b0;
         eb = (i < 11) ? vtab[i] : ((i == 12) ? 8'hfe : 8'he0);
         `CHK("byte", eb, pc_value[7:0])
         `CHK("page", exp[14:8], pc_value[14:8])
      end
      // trap taken without global enable, then blocks maskables
      tb_start = 1'b1;
      step();
      tb_start = 1'b0;
      `CHK("trap take", 2'b11, {trap_busy, ack_busy})
      step(8);
      swr(3'b001, '0, '0, 1'b1);
      tb_start = 1'b1;
      step();
      tb_start = 1'b0;
      `CHK("trap blocks", 1'b0, ack_busy)
      `CHK("trap flag", 1'b1, trap_pend)
      trap_clear = 1'b1;
      swr(3'b100, '0, '0, 1'b0);
      trap_clear = 1'b0;
      `CHK("trap done", 2'b00, {trap_pend, trap_busy})
      step();
      $display("test vis done");
   endtask

   task automatic t_return;
      swr(3'b111, 11'h001, 11'h000, 1'b1);
      run = 1'b1;
      step(4);
      `CHK("disabled", 1'b0, ack_busy)
      swr(3'b010, '0, 11'h001, 1'b0);
      for (k = 0; k < 4 && ack_busy !== 1'b1; k++) step();
      `CHK("at once", 1'b1, ack_busy)
      // routine clears its flag, then the event repeats
      swr(3'b100, '0, '0, 1'b0);
      src_event = 11'h001;
      step();
      src_event = '0;
      for (k = 0; k < 9 && pc_load !== 1'b1; k++) step();
      step();
      exp = pop_addr;
      ret = 1'b1;
      step();
      ret = 1'b0;
      `CHK("gie", 1'b1, global_irq_enable)
      `CHK("pop pc", exp, pc_value)
      for (k = 0; k < 4 && ack_busy !== 1'b1; k++) step();
      `CHK("retake", 1'b1, ack_busy)
      run = 1'b0;
      for (k = 0; k < 9 && pc_load !== 1'b1; k++) step();
      swr(3'b001, '0, '0, 1'b1);
      `CHK("nesting", 1'b1, global_irq_enable)
      $display("test return done");
   endtask

   // watchdog
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      final_report();
   end

   initial begin
      srst = 1'b1;
      {trap_event, trap_clear, tb_start, skip_pending} = '0;
      {vis_go, ret, run} = '0;
      src_event = '0;
      sw = '0;
      n_fail = 0;
      compares = 0;
      step(8);
      srst = 1'b0;
      t_reset();
      t_flags();
      t_ack();
      t_vis();
      t_return();
      final_report();
   end
endmodule
